// File: rtl/debug_exc_pkg.sv
// Shared constants and types for the debug exception condition logic
package debug_exc_pkg;

    // ------------------------------------------------------------
    // Breakpoint access-type encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ACC_EXEC = 2'h0;
    localparam logic [1:0] ACC_WRITE = 2'h1;
    localparam logic [1:0] ACC_IO = 2'h2;
    localparam logic [1:0] ACC_RDWR = 2'h3;

    // ------------------------------------------------------------
    // Register field positions and sizes
    // ------------------------------------------------------------
    localparam int NUM_BKPT = 4;
    localparam int ADDR_W = 32;
    localparam int MSR_BUS_LOCK_BIT = 2;
    localparam int NUM_DEBUG_REGS = 8;
    localparam logic [4:0] DB_VECTOR = 5'h01;
    localparam logic [4:0] BP_VECTOR = 5'h03;

    // ------------------------------------------------------------
    // Status bits held in the debug status register
    // ------------------------------------------------------------
    localparam int ST_B0 = 0;
    localparam int ST_GD = 13;
    localparam int ST_BS = 14;
    localparam int ST_BT = 15;
    localparam int ST_BLD = 11;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // ------------------------------------------------------------
    // One retiring instruction, as seen by this block
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic mem_access;
        logic mem_write;
        logic io_access;
        logic [31:0] addr;
        logic ss_load;
        logic sets_tf;
        logic soft_int;
        logic is_bkpt_instr;
        logic is_rep_io;
        logic rep_first_iter;
        logic fast_string_mid;
        logic dr_access;
        logic bus_lock;
        logic task_switch;
        logic tss_trap_bit;
        logic tss_tf;
        logic fault;
        logic machine_check;
    } retire_s;

    // ------------------------------------------------------------
    // Exception delivery to the core
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic is_fault;
        logic [4:0] vector;
    } exc_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHADOW = 3'b010,
        ST_DEFER = 3'b100
    } pend_e;

endpackage : debug_exc_pkg

// File: rtl/bkpt_match.sv
// Data and I/O breakpoint address comparison
`timescale 1ns/1ps
module bkpt_match
    import debug_exc_pkg::*;
#(
    parameter int N = NUM_BKPT
) (
    // Access
    input wire retire_s ret,
    // Breakpoint setup
    input wire logic [N*ADDR_W-1:0] bkpt_addr,
    input wire logic [N*2-1:0] bkpt_type,
    input wire logic [N-1:0] bkpt_en,
    // Result
    output logic [N-1:0] hit
);
    function automatic logic type_hit(input logic [1:0] t, input retire_s r);
        case (t)
            ACC_WRITE: type_hit = r.mem_access & r.mem_write;
            ACC_IO: type_hit = r.io_access;
            ACC_RDWR: type_hit = r.mem_access;
            default: type_hit = 1'b0;
        endcase
    endfunction : type_hit

    // Exact matching always; exact-match flags are not inputs at all
    always_comb begin
        for (int i = 0; i < N; i++) begin
            hit[i] = ret.valid & bkpt_en[i] & type_hit(bkpt_type[i*2 +: 2], ret)
                & (bkpt_addr[i*ADDR_W +: ADDR_W] == ret.addr);
        end
    end
endmodule : bkpt_match

// File: rtl/step_ctrl.sv
// Single-step trap flag tracking
`timescale 1ns/1ps
module step_ctrl
    import debug_exc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Retire stream
    input wire retire_s ret,
    input wire logic tf_in,
    input wire logic db_taken,
    // Result
    output logic step_trap,
    output logic tf_clear
);
    logic armed_reg;

    // Armed once trap flag was already set at instruction start
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armed_reg <= 1'b0;
        end else if (ret.valid) begin
            armed_reg <= tf_in & ~ret.soft_int & ~db_taken;
        end
    end

    always_comb begin
        step_trap = ret.valid & armed_reg & ~ret.sets_tf & ~ret.ss_load;
        if (ret.task_switch) begin
            step_trap = 1'b0;
        end
        tf_clear = ret.valid & ret.soft_int;
    end
endmodule : step_ctrl

// File: rtl/debug_exc_conditions.sv
// Debug exception condition detection and delivery
//
// Operation
// - Data/IO breakpoint hit traps after instruction
// - Triggering write completes before exception
// - Fast-string hit may wait group end
// - Exact-match enable flags ignored
// - Repeated port strings: IO after first iteration
// - Stack-segment load hit waits one instruction
// - Other exception delivery discards pending breakpoints
// - Software interrupts keep pending breakpoints
// - General detect faults on debug register access
// - Trap flag steps, not after setting it
// - Trap flag cleared before step handler
// - Incoming task trap flag steps after first
// - Trap flag kept; software interrupts clear it
// - Step before coincident external interrupt
// - No step after stack-segment load
// - Task trap bit raises debug before first
// - Bus lock traps after locking instruction
// - Bus lock detect enabled, privilege above zero
// - One-byte breakpoint raises vector three
// - Access-type field encodings
`timescale 1ns/1ps
module debug_exc_conditions
    import debug_exc_pkg::*;
#(
    parameter int N = NUM_BKPT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Retiring instruction
    input wire retire_s ret,
    input wire logic [1:0] current_privilege_level,
    input wire logic ext_irq_pending,
    input wire logic trap_flag,
    // Breakpoint and control setup
    input wire logic [N*ADDR_W-1:0] bkpt_addr,
    input wire logic [N*2-1:0] bkpt_type,
    input wire logic [N-1:0] bkpt_en,
    input wire logic general_detect_enable,
    input wire logic global_exact_match,
    input wire logic local_exact_match,
    input wire logic [15:0] debug_control_msr,
    input wire logic status_clear,
    // Exception delivery
    output exc_s exc_out,
    output logic trap_flag_clear,
    output logic ext_irq_take,
    output logic write_commit,
    output logic [15:0] debug_status_reg,
    output logic general_detect_clear
);
    logic [N-1:0] hit;
    logic step_trap;
    logic tf_clr_soft;
    logic db_now;
    pend_e pend_reg;
    logic [N-1:0] pend_hits_reg;
    logic task_step_reg;
    logic [N-1:0] cur_hits;
    logic bp_hit;
    logic lock_trap;
    logic gd_fault;
    logic other_exc;

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    bkpt_match #(.N(N)) u_match (
        .ret(ret),
        .bkpt_addr(bkpt_addr),
        .bkpt_type(bkpt_type),
        .bkpt_en(bkpt_en),
        .hit(hit)
    );

    step_ctrl u_step (
        .clk(clk),
        .resetn(resetn),
        .ret(ret),
        .tf_in(trap_flag),
        .db_taken(db_now),
        .step_trap(step_trap),
        .tf_clear(tf_clr_soft)
    );

    // ------------------------------------------------------------
    // Condition decode
    // ------------------------------------------------------------
    always_comb begin
        // IO hits on repeated port strings report on the first iteration only
        cur_hits = hit;
        if (ret.is_rep_io && !ret.rep_first_iter) begin
            for (int i = 0; i < N; i++) begin
                if (bkpt_type[i*2 +: 2] == ACC_IO) begin
                    cur_hits[i] = 1'b0;
                end
            end
        end
        bp_hit = |cur_hits;
        gd_fault = ret.valid & general_detect_enable & ret.dr_access;
        lock_trap = ret.valid & ret.bus_lock & debug_control_msr[MSR_BUS_LOCK_BIT]
            & (current_privilege_level != 2'h0);
        other_exc = ret.valid & (ret.fault | ret.machine_check);
        db_now = exc_out_next_db();
    end

    function automatic logic exc_out_next_db();
        exc_out_next_db = gd_fault | (ret.valid & ret.task_switch & ret.tss_trap_bit)
            | (step_trap & ~other_exc) | lock_trap;
    endfunction : exc_out_next_db

    // ------------------------------------------------------------
    // Pending breakpoint tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_reg <= ST_IDLE;
            pend_hits_reg <= '0;
        end else if (ret.valid) begin
            case (pend_reg)
                ST_IDLE: begin
                    if (bp_hit && !other_exc && ret.ss_load) begin
                        pend_reg <= ST_SHADOW;
                        pend_hits_reg <= cur_hits;
                    end else if (bp_hit && !other_exc && ret.fast_string_mid) begin
                        pend_reg <= ST_DEFER;
                        pend_hits_reg <= cur_hits;
                    end
                end
                ST_SHADOW: begin
                    pend_reg <= ST_IDLE;
                    pend_hits_reg <= '0;
                end
                ST_DEFER: begin
                    if (other_exc || !ret.fast_string_mid) begin
                        pend_reg <= ST_IDLE;
                        pend_hits_reg <= '0;
                    end else begin
                        pend_hits_reg <= pend_hits_reg | cur_hits;
                    end
                end
                default: begin
                    pend_reg <= ST_IDLE;
                    pend_hits_reg <= '0;
                end
            endcase
        end
    end

    // Task trap flag from the incoming image steps after the first instruction
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            task_step_reg <= 1'b0;
        end else if (ret.valid) begin
            task_step_reg <= ret.task_switch & ret.tss_tf;
        end
    end

    // ------------------------------------------------------------
    // Delivery and status
    // ------------------------------------------------------------
    logic [N-1:0] deliver_hits;
    logic db_fire;
    logic step_fire;
    always_comb begin
        deliver_hits = '0;
        if (ret.valid && !other_exc) begin
            case (pend_reg)
                ST_SHADOW: deliver_hits = pend_hits_reg | cur_hits;
                ST_DEFER: deliver_hits = ret.fast_string_mid ? '0
                    : (pend_hits_reg | cur_hits);
                default: deliver_hits = (ret.ss_load || ret.fast_string_mid) ? '0
                    : cur_hits;
            endcase
        end
        step_fire = ((step_trap & ~other_exc) | (ret.valid & task_step_reg & ~other_exc));
        db_fire = gd_fault | step_fire | lock_trap | (|deliver_hits)
            | (ret.valid & ret.task_switch & ret.tss_trap_bit);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            exc_out <= '0;
            write_commit <= 1'b0;
            trap_flag_clear <= 1'b0;
            ext_irq_take <= 1'b0;
            general_detect_clear <= 1'b0;
        end else begin
            // Write commits in the same cycle as the debug trap report, except on a detect fault
            write_commit <= ret.valid & ret.mem_write & ~gd_fault;
            exc_out.valid <= db_fire | (ret.valid & ret.is_bkpt_instr);
            exc_out.is_fault <= gd_fault;
            exc_out.vector <= db_fire ? DB_VECTOR : BP_VECTOR;
            trap_flag_clear <= (db_fire & step_fire) | tf_clr_soft;
            // External interrupt sampled after step entry, if still pending
            ext_irq_take <= step_fire ? 1'b0 : ext_irq_pending;
            general_detect_clear <= gd_fault;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            debug_status_reg <= STATUS_RESET;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (deliver_hits[i]) begin
                    debug_status_reg[ST_B0 + i] <= 1'b1;
                end else if (status_clear) begin
                    debug_status_reg[ST_B0 + i] <= 1'b0;
                end
            end
            if (gd_fault) begin
                debug_status_reg[ST_GD] <= 1'b1;
            end else if (status_clear) begin
                debug_status_reg[ST_GD] <= 1'b0;
            end
            if (step_fire) begin
                debug_status_reg[ST_BS] <= 1'b1;
            end else if (status_clear) begin
                debug_status_reg[ST_BS] <= 1'b0;
            end
            if (ret.valid && ret.task_switch && ret.tss_trap_bit) begin
                debug_status_reg[ST_BT] <= 1'b1;
            end else if (status_clear) begin
                debug_status_reg[ST_BT] <= 1'b0;
            end
            if (lock_trap) begin
                debug_status_reg[ST_BLD] <= 1'b0;
            end else if (status_clear) begin
                debug_status_reg[ST_BLD] <= 1'b1;
            end
        end
    end

    logic unused_exact;
    assign unused_exact = global_exact_match ^ local_exact_match;
endmodule : debug_exc_conditions

// File: testbench/debug_exc_conditions_checker.sv
// Assertions on the ports of the debug exception condition logic
`timescale 1ns/1ps
module debug_exc_conditions_checker
    import debug_exc_pkg::*;
#(
    parameter int N = NUM_BKPT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Retiring instruction
    input wire retire_s ret,
    input wire logic [1:0] current_privilege_level,
    input wire logic ext_irq_pending,
    input wire logic trap_flag,
    // Setup
    input wire logic [N*ADDR_W-1:0] bkpt_addr,
    input wire logic [N*2-1:0] bkpt_type,
    input wire logic [N-1:0] bkpt_en,
    input wire logic general_detect_enable,
    input wire logic global_exact_match,
    input wire logic local_exact_match,
    input wire logic [15:0] debug_control_msr,
    input wire logic status_clear,
    // Delivery
    input wire exc_s exc_out,
    input wire logic trap_flag_clear,
    input wire logic ext_irq_take,
    input wire logic write_commit,
    input wire logic [15:0] debug_status_reg,
    input wire logic general_detect_clear
);
    // ------
    // Properties
    // ------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic ok_rec;
    assign ok_rec = ret.valid && !ret.fault && !ret.machine_check;

    chk_bp_vector: assert property (ok_rec && ret.is_bkpt_instr
        |=> exc_out.valid && exc_out.vector == BP_VECTOR) else $error("bad breakpoint vector");
    chk_gd_fault: assert property (ok_rec && ret.dr_access && general_detect_enable
        |=> exc_out.valid && exc_out.is_fault && debug_status_reg[ST_GD] && general_detect_clear)
        else $error("detect fault missing");
    chk_exc_cause: assert property (exc_out.valid |-> $past(ret.valid))
        else $error("exception without record");
    chk_fault_cancel: assert property (ret.valid && (ret.fault || ret.machine_check)
        && !ret.dr_access && !ret.is_bkpt_instr |=> !exc_out.valid) else $error("not cancelled");
    chk_lock_trap: assert property (ok_rec && ret.bus_lock && current_privilege_level != 2'h0
        && debug_control_msr[MSR_BUS_LOCK_BIT] |=> exc_out.valid && !exc_out.is_fault
        && !debug_status_reg[ST_BLD]) else $error("bus lock trap wrong");
    chk_lock_kernel: assert property (ret.valid && ret.bus_lock && current_privilege_level == 2'h0
        && !status_clear |=> $stable(debug_status_reg[ST_BLD])) else $error("lock flag moved");
    chk_task_bt: assert property (ok_rec && ret.task_switch && ret.tss_trap_bit
        |=> exc_out.valid && debug_status_reg[ST_BT]) else $error("task trap missing");
    chk_step_clear: assert property ($rose(debug_status_reg[ST_BS])
        |-> exc_out.valid && trap_flag_clear) else $error("step without flag clear");
    chk_commit_src: assert property (write_commit |-> $past(ret.valid && ret.mem_write))
        else $error("commit without write");

    cover property (exc_out.valid && exc_out.is_fault);
    cover property (exc_out.valid && exc_out.vector == BP_VECTOR);
    cover property ($rose(debug_status_reg[ST_BS]));
endmodule : debug_exc_conditions_checker

bind debug_exc_conditions debug_exc_conditions_checker #(.N(N)) i_chk (
    .clk(clk), .resetn(resetn), .ret(ret), .current_privilege_level(current_privilege_level),
    .ext_irq_pending(ext_irq_pending), .trap_flag(trap_flag), .bkpt_addr(bkpt_addr),
    .bkpt_type(bkpt_type), .bkpt_en(bkpt_en), .general_detect_enable(general_detect_enable),
    .global_exact_match(global_exact_match), .local_exact_match(local_exact_match),
    .debug_control_msr(debug_control_msr), .status_clear(status_clear), .exc_out(exc_out),
    .trap_flag_clear(trap_flag_clear), .ext_irq_take(ext_irq_take),
    .write_commit(write_commit), .debug_status_reg(debug_status_reg),
    .general_detect_clear(general_detect_clear)
);

// File: testbench/tb_debug_exc_conditions.sv
// Testbench for the debug exception condition logic
`timescale 1ns/1ps
module tb_debug_exc_conditions
    import debug_exc_pkg::*;
;
    // ------
    // Signals
    // ------
    typedef struct packed {
        logic [1:0] acc;
        logic [1:0] priv;
        logic [3:0] kind;
        logic [31:0] addr;
        exc_s e;
        logic [3:0] sb;
        logic sv;
    } row_s;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    retire_s ret = '0;
    retire_s r;
    retire_s q;
    logic [1:0] priv = 2'h3;
    logic irq = 1'b0;
    logic step_flag = 1'b0;
    logic det_en = 1'b0;
    logic gx_en = 1'b0;
    logic lx_en = 1'b0;
    logic sclr = 1'b0;
    logic [15:0] ctl_msr = 16'h0004;
    logic [4*ADDR_W-1:0] baddr = {32'h4000, 32'h3000, 32'h2000, 32'h1000};
    logic [7:0] btype = 8'h55;
    logic [3:0] ben = 4'h1;
    exc_s exc;
    logic flag_clr;
    logic irq_take;
    logic commit;
    logic det_clr;
    logic [15:0] status;
    row_s rows[$];
    int num_errors = 0;
    int check_count = 0;

    debug_exc_conditions #(.N(4)) i_dut (
        .clk(clk), .resetn(resetn), .ret(ret), .current_privilege_level(priv),
        .ext_irq_pending(irq), .trap_flag(step_flag), .bkpt_addr(baddr),
        .bkpt_type(btype), .bkpt_en(ben), .general_detect_enable(det_en),
        .global_exact_match(gx_en), .local_exact_match(lx_en),
        .debug_control_msr(ctl_msr), .status_clear(sclr), .exc_out(exc),
        .trap_flag_clear(flag_clr), .ext_irq_take(irq_take), .write_commit(commit),
        .debug_status_reg(status), .general_detect_clear(det_clr)
    );

    // ------
    // Tasks
    // ------
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk1(input string n, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", n, e, s);
        end
    endtask : chk1

    task automatic chk_exc(input exc_s e);
        check_count++;
        if (exc.valid !== e.valid || (e.valid && exc[5:0] !== e[5:0])) begin
            num_errors++;
            $display("BAD exc_out expected %h seen %h", e, exc);
        end
    endtask : chk_exc

    function automatic retire_s mk(input logic [3:0] k, input logic [31:0] a);
        retire_s x;
        x = '0;
        x.valid = 1'b1;
        x.addr = a;
        x.mem_access = (k < 4'h2);
        x.mem_write = (k == 4'h0);
        x.io_access = (k == 4'h2);
        x.is_rep_io = (k == 4'h2);
        x.rep_first_iter = (k == 4'h2);
        x.dr_access = (k == 4'h3);
        x.is_bkpt_instr = (k == 4'h4);
        x.soft_int = (k == 4'h4);
        x.bus_lock = (k == 4'h5);
        x.task_switch = (k == 4'h6);
        x.tss_trap_bit = (k == 4'h6);
        return x;
    endfunction : mk

    task automatic add(input logic [1:0] t, input logic [1:0] p, input logic [3:0] k,
                       input logic [31:0] a, input exc_s e, input int sb, input logic sv);
        rows.push_back(row_s'{t, p, k, a, e, sb[3:0], sv});
    endtask : add

    task automatic send(input retire_s x);
        @(negedge clk);
        ret = x;
        @(negedge clk);
        ret = '0;
    endtask : send

    // ------
    // Sequence
    // ------
    initial begin
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        close_out();
    end

    initial begin
        repeat (16) @(negedge clk);
        chk_exc(7'h00);
        chk1("status", 1'b1, status === 16'h0000);
        resetn = 1'b1;
        $display("reset test done");
        add(2'h1, 2'h3, 4'h0, 32'h1000, 7'h41, ST_B0, 1'b1);
        add(2'h3, 2'h3, 4'h1, 32'h1000, 7'h41, ST_B0, 1'b1);
        add(2'h2, 2'h3, 4'h2, 32'h1000, 7'h41, ST_B0, 1'b1);
        add(2'h0, 2'h3, 4'h0, 32'h1000, 7'h00, ST_B0, 1'b0);
        add(2'h1, 2'h3, 4'h0, 32'h1004, 7'h00, ST_B0, 1'b0);
        add(2'h1, 2'h3, 4'h3, 32'h0, 7'h61, ST_GD, 1'b1);
        add(2'h1, 2'h3, 4'h3, 32'h0, 7'h00, ST_GD, 1'b0);
        add(2'h1, 2'h3, 4'h4, 32'h0, 7'h43, ST_B0, 1'b0);
        add(2'h1, 2'h3, 4'h5, 32'h0, 7'h41, ST_BLD, 1'b0);
        add(2'h1, 2'h0, 4'h5, 32'h0, 7'h00, ST_BLD, 1'b1);
        add(2'h1, 2'h1, 4'h5, 32'h0, 7'h00, ST_BLD, 1'b1);
        foreach (rows[i]) begin
            btype = {4{rows[i].acc}};
            priv = rows[i].priv;
            ctl_msr = (rows[i].priv == 2'h1) ? 16'h0000 : 16'h0004;
            det_en = rows[i].e.valid;
            gx_en = i[0];
            lx_en = i[1];
            sclr = 1'b1;
            @(negedge clk);
            sclr = 1'b0;
            send(mk(rows[i].kind, rows[i].addr));
            chk_exc(rows[i].e);
            chk1("status", rows[i].sv, status[rows[i].sb]);
            chk1("detect_clear", rows[i].e.is_fault, det_clr);
            chk1("flag_clear", rows[i].kind == 4'h4, flag_clr);
            chk1("irq_take", 1'b0, irq_take);
            if (rows[i].kind == 4'h0 && rows[i].e.valid)
                chk1("commit", 1'b1, commit);
        end
        $display("table test done");
        btype = 8'h55;
        priv = 2'h3;
        ctl_msr = 16'h0004;
        r = mk(4'h0, 32'h1000);
        r.ss_load = 1'b1;
        send(r);
        chk_exc(7'h00);
        send(mk(4'h7, 32'h0));
        chk_exc(7'h41);
        send(r);
        q = mk(4'h7, 32'h0);
        q.fault = 1'b1;
        send(q);
        chk_exc(7'h00);
        send(mk(4'h7, 32'h0));
        chk_exc(7'h00);
        q = mk(4'h0, 32'h1000);
        q.machine_check = 1'b1;
        send(q);
        chk_exc(7'h00);
        send(r);
        q = mk(4'h7, 32'h0);
        q.soft_int = 1'b1;
        send(q);
        chk_exc(7'h41);
        q = mk(4'h0, 32'h1000);
        q.fast_string_mid = 1'b1;
        send(q);
        chk_exc(7'h00);
        send(mk(4'h7, 32'h0));
        chk_exc(7'h41);
        step_flag = 1'b1;
        irq = 1'b1;
        q = mk(4'h7, 32'h0);
        q.sets_tf = 1'b1;
        send(q);
        chk_exc(7'h00);
        send(mk(4'h7, 32'h0));
        chk_exc(7'h41);
        chk1("flag_clear", 1'b1, flag_clr);
        chk1("step_status", 1'b1, status[ST_BS]);
        chk1("irq_take", 1'b0, irq_take);
        @(negedge clk);
        chk1("irq_take", 1'b1, irq_take);
        send(mk(4'h7, 32'h0));
        chk_exc(7'h00);
        q.sets_tf = 1'b0;
        q.ss_load = 1'b1;
        send(q);
        chk_exc(7'h00);
        step_flag = 1'b0;
        irq = 1'b0;
        send(mk(4'h6, 32'h0));
        chk_exc(7'h41);
        chk1("task_status", 1'b1, status[ST_BT]);
        q = mk(4'h7, 32'h0);
        q.task_switch = 1'b1;
        q.tss_tf = 1'b1;
        send(q);
        chk_exc(7'h00);
        send(mk(4'h7, 32'h0));
        chk_exc(7'h41);
        chk1("flag_clear", 1'b1, flag_clr);
        $display("sequence test done");
        close_out();
    end
endmodule : tb_debug_exc_conditions
